// ---- rtl/xmem_cfg_pkg.sv ----
package xmem_cfg_pkg;

  // register addresses in the special-function space
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'haa;
  localparam logic [7:0] CONFIG_ADDR = 8'hab;

  // values after reset
  localparam logic [4:0] PAGE_RESET = 5'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] STROBE_RESET = 2'h3;

  // field positions
  localparam int PAGE_MSB = 4;
  localparam int MODE_LSB = 2;
  localparam int STROBE_LSB = 0;

  // populated on-chip data space, in bytes
  localparam int ONCHIP_BYTES = 4096;

  // latch strobe phase length is field value plus this many cycles
  localparam int STROBE_EXTRA_CYCLES = 1;

  typedef enum logic [1:0]
  {
    MODE_INTERNAL = 2'h0,
    MODE_SPLIT_NO_BANK = 2'h1,
    MODE_SPLIT_BANK = 2'h2,
    MODE_EXTERNAL = 2'h3
  } op_mode_t;

  // one external data move as issued by the core
  typedef struct packed
  {
    logic paged;
    logic [15:0] addr;
  } move_req_t;

  // where the move lands and how the address pins are driven
  typedef struct packed
  {
    logic offchip;
    logic hi_oe;
    logic lo_oe;
    logic [15:0] addr;
  } route_t;

endpackage : xmem_cfg_pkg

// ---- rtl/latch_strobe_gen.sv ----
`timescale 1ns/10ps
module latch_strobe_gen
  import xmem_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [1:0] width,
  output logic strobe,
  output logic busy,
  output logic done
);

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} strobe_state_t;

  strobe_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] len_r, len_nxt;

  ////////////////////////////////////////////////////////////////////////
  // width is captured at start so a config write mid-cycle cannot stretch it
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          len_nxt = 3'(width) + 3'(STROBE_EXTRA_CYCLES); // R6
          cnt_nxt = 3'h1;
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (cnt_r == len_r) // R6
        begin
          cnt_nxt = 3'h1;
          state_nxt = ST_LOW;
        end
        else
          cnt_nxt = cnt_r + 3'h1;
      end
      ST_LOW:
      begin
        if (cnt_r == len_r) // R6
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r + 3'h1;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      len_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
    end
  end

  assign strobe = (state_r == ST_HIGH);
  assign busy = (state_r != ST_IDLE);
  assign done = (state_r == ST_LOW) && (cnt_r == len_r);

  ////////////////////////////////////////////////////////////////////////
  // high phase lasts exactly width plus one cycles
  property p_strobe_high_len;
    @(posedge ref_clk) disable iff (!rstn)
    (start && !busy && width == 2'h0) |=> strobe ##1 !strobe;
  endproperty
  a_strobe_high_len: assert property (p_strobe_high_len) else $error("strobe high length"); // R6

  property p_strobe_full_len;
    @(posedge ref_clk) disable iff (!rstn)
    (start && !busy && width == 2'h3) |=> strobe [*4] ##1 (!strobe && busy) [*4] ##1 !busy;
  endproperty
  a_strobe_full_len: assert property (p_strobe_full_len) else $error("strobe phases wrong"); // R6

  c_strobe_mid: cover property (@(posedge ref_clk) disable iff (!rstn)
    start && !busy && width == 2'h1);

endmodule : latch_strobe_gen

// ---- rtl/ext_memory_page_and_mode_config.sv ----
// Behaviour
// R1: bits 7:5 of the page-select register read as zero and ignore writes.
// R2: a paged move takes its high address byte from the five-bit page field.
// R3: page field top bit set in a split mode sends a paged move off-chip.
// R4: with the top bit set, the lower four page bits pick the off-chip page.
// R5: mode field 00 internal, 01 split no bank, 10 split with bank, 11 external only.
// R6: latch strobe high and low times are each the width field plus one cycles.
// R7: bits 7:4 of the configuration register read as zero and ignore writes.
// R8: internal-only mode keeps every move on-chip, wrapping high addresses.
// R9: split without bank drives only A7:0 on a paged off-chip move, all 12 on a pointer move.
// R10: split with bank drives A11:8 from the page and A7:0 from the low byte on paged moves.
// R11: external-only sends every move off-chip; paged moves ignore the page and leave A11:8.
// R12: reset gives internal-only mode, page zero and a four-cycle latch strobe.
`timescale 1ns/10ps
module ext_memory_page_and_mode_config
  import xmem_cfg_pkg::*;
#(
  parameter int ONCHIP_SIZE = ONCHIP_BYTES
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic move_valid,
  output logic move_ready,
  input wire move_req_t move,
  output route_t route,
  output logic move_done,
  output logic ale
);

  logic [4:0] page_r, page_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [1:0] strobe_w_r, strobe_w_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  route_t route_r, route_nxt;
  logic done_r, done_nxt;
  logic accept;
  logic strobe_start;
  logic strobe_busy;
  logic strobe_done;
  route_t route_now;

  ////////////////////////////////////////////////////////////////////////
  // register file: only the documented fields are stored
  always_comb
  begin
    page_nxt = page_r;
    mode_nxt = mode_r;
    strobe_w_nxt = strobe_w_r;
    rdata_nxt = rdata_r;
    if (sfr_wr && sfr_addr == PAGE_SELECT_ADDR)
      page_nxt = sfr_wdata[PAGE_MSB:0]; // R1 R2
    if (sfr_wr && sfr_addr == CONFIG_ADDR)
    begin
      mode_nxt = sfr_wdata[MODE_LSB+1:MODE_LSB]; // R5 R7
      strobe_w_nxt = sfr_wdata[STROBE_LSB+1:STROBE_LSB]; // R6 R7
    end
    if (sfr_rd)
    begin
      case (sfr_addr)
        PAGE_SELECT_ADDR: rdata_nxt = {3'h0, page_r}; // R1
        CONFIG_ADDR: rdata_nxt = {4'h0, mode_r, strobe_w_r}; // R7
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // reset leaves internal-only, page zero, widest strobe
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      page_r <= PAGE_RESET; // R12
      mode_r <= MODE_RESET; // R12
      strobe_w_r <= STROBE_RESET; // R12
      rdata_r <= 8'h00;
    end
    else
    begin
      page_r <= page_nxt;
      mode_r <= mode_nxt;
      strobe_w_r <= strobe_w_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // address routing; on-chip size must be a power of two for the wrap mask
  function automatic route_t route_fn(input logic [1:0] mode, input logic [4:0] page,
                                      input move_req_t mv);
    route_t r;
    logic [15:0] eff;
    logic above;
    eff = mv.paged ? {3'h0, page, mv.addr[7:0]} : mv.addr; // R2
    above = (32'(eff) >= ONCHIP_SIZE);
    r.offchip = 1'b0;
    r.hi_oe = 1'b0;
    r.lo_oe = 1'b0;
    r.addr = eff;
    case (op_mode_t'(mode)) // R5
      MODE_INTERNAL:
        r.addr = eff & 16'(ONCHIP_SIZE - 1); // R8
      MODE_SPLIT_NO_BANK, MODE_SPLIT_BANK:
      begin
        if (mv.paged)
        begin
          r.offchip = page[PAGE_MSB]; // R3
          if (page[PAGE_MSB])
            r.addr = {4'h0, page[3:0], mv.addr[7:0]}; // R4
          // pins A11:8 stay with the port latches without bank select
          r.hi_oe = page[PAGE_MSB] && (op_mode_t'(mode) == MODE_SPLIT_BANK); // R9 R10
        end
        else
        begin
          r.offchip = above;
          r.hi_oe = above; // R9 R10
        end
      end
      MODE_EXTERNAL:
      begin
        r.offchip = 1'b1; // R11
        if (mv.paged)
          r.addr = {8'h00, mv.addr[7:0]}; // R11
        r.hi_oe = !mv.paged; // R11
      end
      default: r.offchip = 1'b0;
    endcase
    r.lo_oe = r.offchip;
    return r;
  endfunction : route_fn

  assign route_now = route_fn(mode_r, page_r, move);

  ////////////////////////////////////////////////////////////////////////
  // one move in flight; off-chip moves wait for the full latch strobe
  assign move_ready = !strobe_busy;
  assign accept = move_valid && move_ready;
  assign strobe_start = accept && route_now.offchip;

  always_comb
  begin
    route_nxt = route_r;
    done_nxt = 1'b0;
    if (accept)
    begin
      route_nxt = route_now;
      done_nxt = !route_now.offchip;
    end
    if (strobe_done)
      done_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      route_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      route_r <= route_nxt;
      done_r <= done_nxt;
    end
  end

  assign route = route_r;
  assign move_done = done_r;

  // strobe width is sampled from the live config field at move start
  latch_strobe_gen u_strobe
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(strobe_start),
    .width(strobe_w_r), // R6
    .strobe(ale),
    .busy(strobe_busy),
    .done(strobe_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic first_r;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  property p_page_rsv;
    (sfr_rd && sfr_addr == PAGE_SELECT_ADDR) |=> sfr_rdata[7:5] == 3'h0;
  endproperty
  a_page_rsv: assert property (p_page_rsv) else $error("page upper bits not zero"); // R1

  property p_page_hi;
    (accept && move.paged && (mode_r == 2'h1 || mode_r == 2'h2) && !page_r[PAGE_MSB])
      |=> route.addr[15:8] == {3'h0, $past(page_r)};
  endproperty
  a_page_hi: assert property (p_page_hi) else $error("paged high byte wrong"); // R2

  property p_split_off;
    (accept && move.paged && page_r[PAGE_MSB] && (mode_r == 2'h1 || mode_r == 2'h2))
      |=> route.offchip && route.addr[11:8] == $past(page_r[3:0]);
  endproperty
  a_split_off: assert property (p_split_off) else $error("split paged move not off-chip"); // R3

  property p_off_page;
    (accept && move.paged && page_r == 5'h11 && mode_r == 2'h1)
      |=> route.addr[15:8] == 8'h01;
  endproperty
  a_off_page: assert property (p_off_page) else $error("off-chip page wrong"); // R4

  // upper config bits never come back on a read
  property p_cfg_rsv;
    (sfr_rd && sfr_addr == CONFIG_ADDR) |=> sfr_rdata[7:4] == 4'h0;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config readback wrong"); // R7

  // only the low nibble of a config write is stored
  property p_cfg_wr;
    (sfr_wr && sfr_addr == CONFIG_ADDR) |=> {mode_r, strobe_w_r} == $past(sfr_wdata[3:0]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write not stored"); // R5 R6 R7

  property p_internal;
    (accept && mode_r == 2'h0) |=> !route.offchip && route.addr < 16'(ONCHIP_SIZE) ##0 move_done;
  endproperty
  a_internal: assert property (p_internal) else $error("internal mode left chip"); // R8

  property p_nobank;
    (accept && move.paged && page_r[PAGE_MSB] && mode_r == 2'h1) |=> !route.hi_oe && route.lo_oe;
  endproperty
  a_nobank: assert property (p_nobank) else $error("upper pins driven without bank"); // R9

  property p_bank;
    (accept && move.paged && page_r[PAGE_MSB] && mode_r == 2'h2) |=> route.hi_oe;
  endproperty
  a_bank: assert property (p_bank) else $error("bank select pins not driven"); // R10

  property p_external;
    (accept && mode_r == 2'h3) |=> route.offchip && (route.hi_oe == !$past(move.paged)) && ale;
  endproperty
  a_external: assert property (p_external) else $error("external mode routing wrong"); // R11

  property p_reset_vals;
    first_r |-> page_r == 5'h00 && mode_r == 2'h0 && strobe_w_r == 2'h3;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R12

  c_split_paged: cover property (accept && move.paged && mode_r == 2'h1 && page_r[PAGE_MSB]);
  c_bank_paged: cover property (accept && move.paged && mode_r == 2'h2 && page_r[PAGE_MSB]);
  c_ext_ptr: cover property (accept && !move.paged && mode_r == 2'h3);
  c_wrap: cover property (accept && !move.paged && mode_r == 2'h0 && move.addr[15:12] != 4'h0);

endmodule : ext_memory_page_and_mode_config

// ---- verif/latch_sram_model.sv ----
`timescale 1ns/10ps
module latch_sram_model
  import xmem_cfg_pkg::*;
#(
  // level left on A11:8 by the port latches when the interface does not drive them
  parameter logic [3:0] PORT_LATCH_HI = 4'ha
)
(
  input wire logic ref_clk,
  input wire logic ale,
  input wire route_t route,
  output logic [11:0] latched_addr
);
  ////////////////////////////////////////////////////////////////////////////
  // transparent address latch, frozen once the strobe falls
  // undriven upper lines show the port latch, never the last route value
  always_ff @(posedge ref_clk)
  begin
    if (ale)
    begin
      latched_addr <= {route.hi_oe ? route.addr[11:8] : PORT_LATCH_HI, route.addr[7:0]};
    end
  end
endmodule : latch_sram_model

// ---- verif/ext_memory_page_and_mode_config_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module ext_memory_page_and_mode_config_tb;
  import xmem_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic move_valid = 1'b0;
  logic move_ready;
  move_req_t move = '0;
  route_t route;
  logic move_done;
  logic ale;
  logic [11:0] latched_addr;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  ext_memory_page_and_mode_config u_dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .move_valid(move_valid), .move_ready(move_ready), .move(move), .route(route),
    .move_done(move_done), .ale(ale));
  latch_sram_model u_mem (.ref_clk(ref_clk), .ale(ale), .route(route),
    .latched_addr(latched_addr));

  // 8 ns clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-byte register access; strobes last exactly one edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : sfr_read

  // one move; off-chip moves also have their strobe phases measured
  task automatic mv(input logic pg, input logic [15:0] a, input route_t exp, input int w);
    int n;
    int hi;
    int lo;
    n = 0;
    hi = 0;
    lo = 0;
    @(negedge ref_clk);
    move_valid = 1'b1;
    move = '{pg, a};
    while (move_ready !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    move_valid = 1'b0;
    `CHK("route", exp, route)
    `CHK("move_ready", !exp.offchip, move_ready)
    if (!exp.offchip)
      `CHK("move_done", 1'b1, move_done)
    else
    begin
      `CHK("ale_rise", 1'b1, ale)
      while (ale === 1'b1 && hi < 20)
      begin
        hi++;
        @(negedge ref_clk);
      end
      while (move_done !== 1'b1 && lo < 20)
      begin
        lo++;
        @(negedge ref_clk);
      end
      `CHK("ale_high", w + 1, hi)
      `CHK("ale_low", w + 1, lo)
      `CHK("latched_low", a[7:0], latched_addr[7:0])
      `CHK("latched_high", exp.hi_oe ? exp.addr[11:8] : 4'ha, latched_addr[11:8])
    end
    @(negedge ref_clk);
  endtask : mv

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    sfr_read(PAGE_SELECT_ADDR, rd);
    `CHK("page_reset", 8'h00, rd)
    sfr_read(CONFIG_ADDR, rd);
    `CHK("config_reset", 8'h03, rd)
    `CHK("ale_idle", 1'b0, ale)
    $display("test_reset finished");
  endtask : test_reset

  task automatic test_regs;
    sfr_write(PAGE_SELECT_ADDR, 8'hff);
    sfr_read(PAGE_SELECT_ADDR, rd);
    `CHK("page_mask", 8'h1f, rd)
    sfr_write(CONFIG_ADDR, 8'hf6);
    sfr_read(CONFIG_ADDR, rd);
    `CHK("config_mask", 8'h06, rd)
    sfr_write(8'hac, 8'h5a);
    sfr_read(8'hac, rd);
    `CHK("unmapped", 8'h00, rd)
    $display("test_regs finished");
  endtask : test_regs

  // pointer moves above the on-chip boundary in every mode, and below it in modes 01 and 11 only
  task automatic test_modes;
    route_t hi_tab [4];
    hi_tab = '{'{1'b0, 1'b0, 1'b0, 16'h0234}, '{1'b1, 1'b1, 1'b1, 16'h1234},
      '{1'b1, 1'b1, 1'b1, 16'h1234}, '{1'b1, 1'b1, 1'b1, 16'h1234}};
    for (int m = 0; m < 4; m++)
    begin
      sfr_write(CONFIG_ADDR, {4'h0, m[1:0], 2'h0});
      sfr_read(CONFIG_ADDR, rd);
      `CHK("mode_field", 8'(m << 2), rd)
      mv(1'b0, 16'h1234, hi_tab[m], 0);
      if (m == 1)
        mv(1'b0, 16'h0123, '{1'b0, 1'b0, 1'b0, 16'h0123}, 0);
      if (m == 3)
        mv(1'b0, 16'h0123, '{1'b1, 1'b1, 1'b1, 16'h0123}, 0);
    end
    $display("test_modes finished");
  endtask : test_modes

  // paged moves with the page top bit set and clear
  task automatic test_paged;
    sfr_write(PAGE_SELECT_ADDR, 8'h11);
    sfr_write(CONFIG_ADDR, 8'h00);
    mv(1'b1, 16'hff55, '{1'b0, 1'b0, 1'b0, 16'h0155}, 3);
    sfr_write(CONFIG_ADDR, 8'h04);
    mv(1'b1, 16'hff55, '{1'b1, 1'b0, 1'b1, 16'h0155}, 0);
    sfr_write(CONFIG_ADDR, 8'h08);
    mv(1'b1, 16'h0055, '{1'b1, 1'b1, 1'b1, 16'h0155}, 0);
    sfr_write(CONFIG_ADDR, 8'h0c);
    mv(1'b1, 16'h0055, '{1'b1, 1'b0, 1'b1, 16'h0055}, 0);
    sfr_write(PAGE_SELECT_ADDR, 8'h0f);
    sfr_write(CONFIG_ADDR, 8'h04);
    mv(1'b1, 16'h00aa, '{1'b0, 1'b0, 1'b0, 16'h0faa}, 0);
    $display("test_paged finished");
  endtask : test_paged

  // every strobe width, including the reset width of four cycles
  task automatic test_strobe;
    for (int w = 0; w < 4; w++)
    begin
      sfr_write(CONFIG_ADDR, {4'h0, 2'h3, w[1:0]});
      mv(1'b0, 16'h2000, '{1'b1, 1'b1, 1'b1, 16'h2000}, w);
    end
    $display("test_strobe finished");
  endtask : test_strobe

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // the whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    test_reset();
    test_regs();
    test_modes();
    test_paged();
    test_strobe();
    summarize();
  end
endmodule : ext_memory_page_and_mode_config_tb
